// file: design/ewb_map.svh
// Register map, field positions and counts of the width/wait block.
// Assumes inclusion by the top module and the bench only.
`ifndef EWB_MAP_SVH
`define EWB_MAP_SVH
// ==========================================================
// Addresses
`define EWB_ADDR_BWC 32'h4800_0000
`define EWB_ADDR_CFG 32'h4800_00F0
// ==========================================================
// Width/wait register layout, four bits per bank
`define EWB_BWC_RESET 32'h0000_0000
`define EWB_BWC_WMASK 32'hFFFF_FFF0
`define EWB_FLD_W 4
`define EWB_LANE_BIT 3
`define EWB_WAIT_BIT 2
`define EWB_DW0_LSB 1
// ==========================================================
// Own configuration register layout
`define EWB_CFG_RESET 4'h0
`define EWB_CFG_SIZE_LSB 0
`define EWB_CFG_FOUR_BIT 3
`define EWB_CFG_GRANT_BIT 8
`define EWB_CFG_BUSY_BIT 9
// ==========================================================
// SDRAM bank select
`define EWB_BA_LSB 20
`define EWB_SZ_CODES 7
`define EWB_SZ_FOUR_ONLY 3'h5
`define EWB_SDRAM_BANK 3'h6
// ==========================================================
// Input filtering
`define EWB_SETTLE 3'h5
`endif

// file: design/ewb_pkg.sv
// Types shared by the width/wait block and its bench.
// Assumes ewb_map.svh supplies the numeric constants.
package ewb_pkg;
    typedef logic [2:0] ewb_bank_t;
    typedef enum logic [1:0] {
        EWB_W8 = 2'h0, EWB_W16 = 2'h1, EWB_W32 = 2'h2, EWB_WRSV = 2'h3
    } ewb_width_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_ACCESS = 3'h2, ST_GRANT = 3'h4
    } ewb_state_e;
endpackage : ewb_pkg

// file: design/ewb_acc_if.sv
// Carrier between the controller and its strobe timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ewb_acc_if;
    logic start;
    logic write;
    logic wait_en;
    logic wait_n;
    logic [3:0] tacc;
    logic oe_n;
    logic we_n;
    logic done;
    logic active;
    modport ctrl(output start, write, wait_en, wait_n, tacc, input oe_n, we_n, done, active);
    modport timer(input start, write, wait_en, wait_n, tacc, output oe_n, we_n, done, active);
endinterface : ewb_acc_if

// file: design/ewb_wait_strobe.sv
// Strobe timer: holds the read or write strobe for the access count,
// stretched by the filtered external wait level.
// Assumes wait_n is already synchronised to clk.
`timescale 1ns/10ps
module ewb_wait_strobe (
    input wire logic clk,
    input wire logic rst_n,
    ewb_acc_if.timer acc
);
    logic active_q;
    logic write_q;
    logic wen_q;
    logic rel_q;
    logic done_q;
    logic [3:0] cnt_q;
    logic [3:0] tacc_q;
    logic at_end;
    logic at_sample;

    // ==========================================================
    // Counting
    // bus clock counts
    assign at_end = ({1'b0, cnt_q} >= {1'b0, tacc_q});
    assign at_sample = (5'({1'b0, cnt_q}) + 5'h01) >= {1'b0, tacc_q};

    // Access sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            write_q <= 1'b0;
            wen_q <= 1'b0;
            rel_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= 4'h0;
            tacc_q <= 4'h0;
        end else begin
            done_q <= 1'b0;
            if (acc.start) begin
                active_q <= 1'b1;
                write_q <= acc.write;
                wen_q <= acc.wait_en;
                rel_q <= 1'b0;
                cnt_q <= 4'h1;
                tacc_q <= acc.tacc;
            end else if (active_q && at_end && (rel_q || !wen_q)) begin
                active_q <= 1'b0;
                done_q <= 1'b1;
            end else if (active_q) begin
                // Saturate; the wait input may hold the strobe indefinitely
                if (cnt_q != 4'hF) begin
                    cnt_q <= cnt_q + 4'h1;
                end
                rel_q <= rel_q | (at_sample && acc.wait_n);
            end
        end
    end

    // ==========================================================
    // Strobes
    // same stretch for write
    assign acc.oe_n = !(active_q && !write_q);
    assign acc.we_n = !(active_q && write_q);
    assign acc.done = done_q;
    assign acc.active = active_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_no_early_end;
        active_q && !at_end && !acc.start |=> active_q;
    endproperty
    a_no_early_end: assert property (p_no_early_end) else $error("strobe ended before count");
    property p_wait_hold;
        active_q && wen_q && !rel_q && !acc.start |=> active_q;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("strobe ended while wait low");
    property p_release;
        active_q && at_end && rel_q && !acc.start |=> !active_q && acc.oe_n && acc.we_n && done_q;
    endproperty
    a_release: assert property (p_release) else $error("strobe not released");
    c_stretch: cover property (active_q && wen_q && at_end && !rel_q ##1 active_q);
endmodule : ewb_wait_strobe

// file: design/ewb_mem_ctrl.sv
// Width/wait control register, SDRAM bank select, wait-stretched
// strobes and external bus hand-over of the memory controller.
// Assumes an APB master on CORE_CLK and pins that may be asynchronous.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ewb_map.svh"
// How it works
// - 2MB two-bank: bank select A20
// - 4MB two-bank: bank select A21
// - 8MB: A22, or A[22:21] four-bank
// - 16MB: A23, or A[23:22] four-bank
// - 32MB: A24, or A[24:23] four-bank
// - 64MB four-bank: A[25:24]
// - 128MB four-bank: A[26:25]
// - Low wait input stretches the strobe
// - Wait sampled from access count minus one
// - Strobe ends clock after wait high
// - Write strobe stretched like read strobe
// - Bus request answered by grant low
// - Grant low floats address, data, control
// - Request release ends grant, drive resumes
// - Width/wait register, read-write, resets zero
// - Width codes 8/16/32, banks 7..5
// - Wait enable bits, banks 7..5
// - Lane mode bits, banks 7..5
// - Bank 4 fields at 19..16
// - Bank 3 fields, bank 2 lane bit
// - All counts in bus clocks
// - Lane select is write lane AND strobe
// - Bank 0 width read-only from boot pins
// - Bank 2 wait and width fields
module ewb_mem_ctrl (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ACC_REQ,
    output logic ACC_READY,
    input wire logic ACC_WRITE,
    input wire ewb_pkg::ewb_bank_t ACC_BANK,
    input wire logic [26:0] ACC_ADDR,
    input wire logic [3:0] ACC_TACC,
    input wire logic [3:0] ACC_BE_N,
    input wire logic [31:0] ACC_WDATA,
    output logic [31:0] ACC_RDATA,
    output logic ACC_DONE,
    input wire logic EXT_WAIT_N,
    input wire logic BUS_REQUEST_N,
    output logic BUS_GRANT_N,
    input wire logic [1:0] BOOT_MODE_PINS,
    output logic [26:0] MEM_ADDR_O,
    output logic MEM_ADDR_OE,
    input wire logic [31:0] MEM_DATA_I,
    output logic [31:0] MEM_DATA_O,
    output logic MEM_DATA_OE,
    output logic [7:0] BANK_CHIP_SELECT_N,
    output logic OUTPUT_ENABLE_N,
    output logic WRITE_ENABLE_N,
    output logic [3:0] BYTE_LANE_SELECT_N,
    output logic [1:0] SDRAM_BANK_SEL_O,
    output logic MEM_CTRL_OE
);
    import ewb_pkg::*;

    ewb_state_e st_q;
    ewb_state_e st_d;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] filt_q;
    logic [2:0] settle_q;
    logic [1:0] boot_q;
    logic [31:0] bwc_q;
    logic [3:0] cfg_q;
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic [31:0] wmask;
    logic hit_bwc;
    logic hit_cfg;
    logic req_act;
    logic acc_take;
    logic [3:0] fld;
    logic [3:0] fld_q;
    logic [2:0] bank_q;
    logic [26:0] addr_q;
    logic [3:0] be_n_q;
    logic [1:0] ba_q;
    logic [31:0] acc_rdata_q;
    logic acc_done_q;
    logic [3:0] wlane_n;
    ewb_acc_if acc ();

    // ==========================================================
    // Pin synchronisers, wait [0], request [1], boot [3:2]
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_q <= 4'hF;
            s2_q <= 4'hF;
            s3_q <= 4'hF;
        end else begin
            s1_q <= {BOOT_MODE_PINS, BUS_REQUEST_N, EXT_WAIT_N};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change accepted once second and third stage agree
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_q <= 4'hF;
        end else begin
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // Boot straps caught once the chain has settled after release;
    // the filter only shows the pins from the fourth edge on
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_q <= 3'h0;
            boot_q <= 2'h0;
        end else if (settle_q != `EWB_SETTLE) begin
            settle_q <= settle_q + 3'h1;
            boot_q <= filt_q[3:2];
        end
    end

    assign req_act = !filt_q[1];

    // ==========================================================
    // APB slave, zero wait states
    assign hit_bwc = (PADDR == `EWB_ADDR_BWC);
    assign hit_cfg = (PADDR == `EWB_ADDR_CFG);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit_bwc && !hit_cfg;
    assign wmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}} & `EWB_BWC_WMASK;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bwc_q <= `EWB_BWC_RESET;
        end else if (PSEL && PENABLE && PWRITE && hit_bwc) begin
            bwc_q <= (bwc_q & ~wmask) | (PWDATA & wmask);
        end
    end

    // Own size and organisation register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= `EWB_CFG_RESET;
        end else if (PSEL && PENABLE && PWRITE && hit_cfg && PSTRB[0]) begin
            cfg_q <= PWDATA[3:0];
        end
    end

    // Read mux; status bits show hand-over and access state
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_bwc) begin
            rd_d = bwc_q & `EWB_BWC_WMASK;
            rd_d[`EWB_DW0_LSB +: 2] = boot_q;
        end else if (hit_cfg) begin
            rd_d[3:0] = cfg_q;
            rd_d[`EWB_CFG_GRANT_BIT] = (st_q == ST_GRANT);
            rd_d[`EWB_CFG_BUSY_BIT] = (st_q == ST_ACCESS);
        end
    end

    // Read data loaded in setup so it comes from a flip-flop
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            rdata_q <= rd_d;
        end
    end
    assign PRDATA = rdata_q;

    // ==========================================================
    // Per-bank field lookup
    // four-bit fields
    always_comb begin
        fld = bwc_q[{ACC_BANK, 2'h0} +: `EWB_FLD_W];
        if (ACC_BANK == 3'h0) begin
            fld = {2'h0, boot_q};
        end
    end

    // SDRAM bank select from size code and organisation
    function automatic logic [1:0] bank_sel(input logic [26:0] a, input logic [2:0] sz, input logic four);
        logic [1:0] ba;
        ba = 2'h0;
        for (int i = 0; i < `EWB_SZ_CODES; i++) begin
            if (sz == 3'(i)) begin
                // Four-bank parts add the line just below the two-bank select
                if (four || sz >= `EWB_SZ_FOUR_ONLY) begin
                    ba = {a[`EWB_BA_LSB + i], a[`EWB_BA_LSB + i - 1]};
                end else begin
                    ba = {1'b0, a[`EWB_BA_LSB + i]};
                end
            end
        end
        return ba;
    endfunction : bank_sel

    // ==========================================================
    // Access and hand-over sequencing
    assign ACC_READY = (st_q == ST_IDLE) && !req_act;
    assign acc_take = ACC_REQ && ACC_READY;

    // One-hot control states
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (req_act) begin
                    st_d = ST_GRANT;
                end else if (ACC_REQ) begin
                    st_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (acc.done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_GRANT: begin
                if (!req_act) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Access latch; held for the whole strobe
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bank_q <= 3'h0;
            addr_q <= 27'h0;
            be_n_q <= 4'hF;
            fld_q <= 4'h0;
            ba_q <= 2'h0;
            MEM_DATA_O <= 32'h0000_0000;
        end else if (acc_take) begin
            bank_q <= ACC_BANK;
            addr_q <= ACC_ADDR;
            be_n_q <= ACC_BE_N;
            fld_q <= fld;
            MEM_DATA_O <= ACC_WDATA;
            ba_q <= bank_sel(ACC_ADDR, cfg_q[`EWB_CFG_SIZE_LSB +: 3], cfg_q[`EWB_CFG_FOUR_BIT]);
        end
    end

    // Read data captured at the edge that ends the strobe
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            acc_rdata_q <= 32'h0000_0000;
            acc_done_q <= 1'b0;
        end else begin
            acc_done_q <= acc.done;
            if (acc.active && !acc.oe_n) begin
                acc_rdata_q <= MEM_DATA_I;
            end
        end
    end
    assign ACC_RDATA = acc_rdata_q;
    assign ACC_DONE = acc_done_q;

    // ==========================================================
    // Strobe timer
    assign acc.start = acc_take;
    assign acc.write = ACC_WRITE;
    assign acc.tacc = ACC_TACC;
    assign acc.wait_en = fld[`EWB_WAIT_BIT];
    assign acc.wait_n = filt_q[0];

    ewb_wait_strobe u_strobe (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .acc(acc.timer)
    );

    // ==========================================================
    // Pin drive
    assign wlane_n = acc.we_n ? 4'hF : be_n_q;
    assign OUTPUT_ENABLE_N = acc.oe_n;
    assign WRITE_ENABLE_N = acc.we_n;
    // lane select is AND of strobes
    assign BYTE_LANE_SELECT_N = fld_q[`EWB_LANE_BIT] ? (wlane_n & {4{acc.oe_n}}) : wlane_n;
    assign BANK_CHIP_SELECT_N = acc.active ? ~(8'h01 << bank_q) : 8'hFF;
    assign SDRAM_BANK_SEL_O = (bank_q >= `EWB_SDRAM_BANK) ? ba_q : 2'h0;
    // Memory address drops the low lines the bus width covers
    assign MEM_ADDR_O = addr_q >> fld_q[1:0];
    assign BUS_GRANT_N = (st_q != ST_GRANT);
    assign MEM_ADDR_OE = (st_q != ST_GRANT);
    assign MEM_CTRL_OE = (st_q != ST_GRANT);
    assign MEM_DATA_OE = (st_q == ST_ACCESS) && !acc.we_n;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_grant;
        st_q == ST_IDLE && req_act |=> !BUS_GRANT_N;
    endproperty
    a_grant: assert property (p_grant) else $error("request not granted");
    property p_float;
        !BUS_GRANT_N |-> !MEM_ADDR_OE && !MEM_CTRL_OE && !MEM_DATA_OE && OUTPUT_ENABLE_N;
    endproperty
    a_float: assert property (p_float) else $error("bus driven while granted");
    property p_release;
        !BUS_GRANT_N && !req_act |=> BUS_GRANT_N && MEM_ADDR_OE;
    endproperty
    a_release: assert property (p_release) else $error("grant not released");
    property p_bwc_wr;
        PSEL && PENABLE && PWRITE && hit_bwc && PSTRB == 4'hF |=> bwc_q == ($past(PWDATA) & `EWB_BWC_WMASK);
    endproperty
    a_bwc_wr: assert property (p_bwc_wr) else $error("register write lost");
    property p_boot_rd;
        PSEL && !PENABLE && hit_bwc |=> PRDATA[`EWB_DW0_LSB +: 2] == $past(boot_q);
    endproperty
    a_boot_rd: assert property (p_boot_rd) else $error("bank 0 width wrong");
    property p_lane;
        acc.active && fld_q[`EWB_LANE_BIT] && !acc.oe_n |-> BYTE_LANE_SELECT_N == 4'h0;
    endproperty
    a_lane: assert property (p_lane) else $error("lane select not active on read");
    property p_ba8;
        acc_take && cfg_q == 4'hA |=> ba_q == {$past(ACC_ADDR[22]), $past(ACC_ADDR[21])};
    endproperty
    a_ba8: assert property (p_ba8) else $error("8MB four-bank select wrong");
    property p_ba2;
        acc_take && cfg_q == 4'h0 |=> ba_q == {1'b0, $past(ACC_ADDR[20])};
    endproperty
    a_ba2: assert property (p_ba2) else $error("2MB bank select wrong");
    property p_ba64;
        acc_take && cfg_q[2:0] == 3'h5 |=> ba_q == {$past(ACC_ADDR[25]), $past(ACC_ADDR[24])};
    endproperty
    a_ba64: assert property (p_ba64) else $error("64MB bank select wrong");
    c_grant: cover property (st_q == ST_GRANT ##1 st_q == ST_IDLE);
    c_read: cover property (acc_take && !ACC_WRITE ##[4:40] ACC_DONE);
    c_write: cover property (acc_take && ACC_WRITE ##[1:40] ACC_DONE);
endmodule : ewb_mem_ctrl

// file: dv/ewb_mem_model.sv
// Far-side SRAM model: read data onto the bus and the wait pin.
// Assumes the strobes change just after the rising clock edge.
`timescale 1ns/10ps
module ewb_mem_model (
    input wire logic clk,
    input wire logic strobe_n,
    input wire logic oe_n,
    input wire logic [3:0] hold,
    input wire logic [31:0] word,
    output logic [31:0] data,
    output logic wait_n
);
    logic [3:0] cnt_q;
    // Strobe-low cycle count, saturating
    always_ff @(posedge clk) begin
        cnt_q <= strobe_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    end
    assign wait_n = strobe_n | (cnt_q >= hold);
    // Released bus toggles so stale data never looks valid
    initial data = 32'h0;
    always @(posedge clk) begin
        data <= oe_n ? ~data : word;
    end
endmodule : ewb_mem_model

// file: dv/test_ewb_mem_ctrl.sv
// Bench for the width/wait block: register, access port, hand-over.
// Assumes one 200 MHz clock and the memory model beside the pins.
`timescale 1ns/10ps
`include "ewb_map.svh"
module test_ewb_mem_ctrl;
    import ewb_pkg::*;
    logic CORE_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, ACC_WDATA = 32'h0, ACC_RDATA, MEM_DATA_I, MEM_DATA_O;
    logic [3:0] PSTRB = 4'hF, ACC_TACC = 4'h2, ACC_BE_N = 4'hF, BYTE_LANE_SELECT_N, hold = 4'h0;
    logic PREADY, PSLVERR, ACC_REQ = 1'b0, ACC_READY, ACC_WRITE = 1'b0, ACC_DONE, EXT_WAIT_N;
    logic BUS_REQUEST_N = 1'b1, BUS_GRANT_N, MEM_ADDR_OE, MEM_DATA_OE, OUTPUT_ENABLE_N, WRITE_ENABLE_N;
    logic MEM_CTRL_OE, err, doe, csl;
    ewb_bank_t ACC_BANK = 3'h0;
    logic [26:0] ACC_ADDR = 27'h0, MEM_ADDR_O;
    logic [1:0] BOOT_MODE_PINS = 2'h1, SDRAM_BANK_SEL_O, bsel;
    logic [7:0] BANK_CHIP_SELECT_N;
    logic [31:0] rd, dout, ard, word = 32'hC3A5_0F96, pat;
    logic [3:0] lanes;
    int miscompares = 0, n_compared = 0, len, len_r;

    ewb_mem_ctrl ewb_mem_ctrl_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .ACC_REQ(ACC_REQ), .ACC_READY(ACC_READY), .ACC_WRITE(ACC_WRITE), .ACC_BANK(ACC_BANK),
        .ACC_ADDR(ACC_ADDR), .ACC_TACC(ACC_TACC), .ACC_BE_N(ACC_BE_N), .ACC_WDATA(ACC_WDATA),
        .ACC_RDATA(ACC_RDATA), .ACC_DONE(ACC_DONE), .EXT_WAIT_N(EXT_WAIT_N), .BUS_REQUEST_N(BUS_REQUEST_N),
        .BUS_GRANT_N(BUS_GRANT_N), .BOOT_MODE_PINS(BOOT_MODE_PINS), .MEM_ADDR_O(MEM_ADDR_O),
        .MEM_ADDR_OE(MEM_ADDR_OE), .MEM_DATA_I(MEM_DATA_I), .MEM_DATA_O(MEM_DATA_O), .MEM_DATA_OE(MEM_DATA_OE),
        .BANK_CHIP_SELECT_N(BANK_CHIP_SELECT_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
        .WRITE_ENABLE_N(WRITE_ENABLE_N), .BYTE_LANE_SELECT_N(BYTE_LANE_SELECT_N),
        .SDRAM_BANK_SEL_O(SDRAM_BANK_SEL_O), .MEM_CTRL_OE(MEM_CTRL_OE));
    ewb_mem_model ewb_mem_model_inst (.clk(CORE_CLK), .strobe_n(OUTPUT_ENABLE_N & WRITE_ENABLE_N),
        .oe_n(OUTPUT_ENABLE_N), .hold(hold), .word(word), .data(MEM_DATA_I), .wait_n(EXT_WAIT_N));

    always #2.5 CORE_CLK = ~CORE_CLK;

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // One memory access; strobe length and first strobe cycle recorded
    task automatic acc(input logic wr, input logic [2:0] bk, input logic [26:0] a, input logic [3:0] be);
        int k;
        @(posedge CORE_CLK);
        ACC_REQ <= 1'b1;
        ACC_WRITE <= wr;
        ACC_BANK <= bk;
        ACC_ADDR <= a;
        ACC_BE_N <= be;
        do @(posedge CORE_CLK); while (ACC_READY !== 1'b1);
        ACC_REQ <= 1'b0;
        len = 0;
        for (k = 0; k < 60 && ACC_DONE !== 1'b1; k++) begin
            @(negedge CORE_CLK);
            if ((OUTPUT_ENABLE_N & WRITE_ENABLE_N) === 1'b0) begin
                if (len == 0) begin
                    lanes = BYTE_LANE_SELECT_N;
                    bsel = SDRAM_BANK_SEL_O;
                    dout = MEM_DATA_O;
                    doe = MEM_DATA_OE;
                    csl = BANK_CHIP_SELECT_N[bk];
                end
                len++;
            end
        end
        ard = ACC_RDATA;
        check("done", k < 60, 1);
        // Return on a rising edge so the caller drives inputs there
        @(posedge CORE_CLK);
    endtask : acc

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        miscompares++;
        close_out();
    end

    // ==========================================================
    // Test sequence
    initial begin
        int k, hi;
        logic fb;
        repeat (10) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        repeat (5) @(posedge CORE_CLK);
        apb(1'b0, `EWB_ADDR_BWC, 32'h0);
        check("reset", rd, {29'h0, BOOT_MODE_PINS, 1'b0});
        for (k = 0; k < 3; k++) begin
            pat = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h5A5A_A5A5 : 32'hA5A5_5A5A;
            apb(1'b1, `EWB_ADDR_BWC, pat);
            apb(1'b0, `EWB_ADDR_BWC, 32'h0);
            check("fields", rd, (pat & 32'hFFFF_FFF0) | 32'h2);
        end
        apb(1'b0, 32'h4800_0004, 32'h0);
        check("unmapped", {err, rd}, 33'h1_0000_0000);
        // Wait stretching, read and write alike; count long enough for
        // the three-stage pin filter to see the wait low before sampling
        ACC_TACC <= 4'h6;
        hold <= 4'h8;
        apb(1'b1, `EWB_ADDR_BWC, 32'h0);
        acc(1'b0, 3'h2, 27'h10, 4'hF);
        check("no wait", len, 6);
        apb(1'b1, `EWB_ADDR_BWC, 32'h400);
        acc(1'b0, 3'h2, 27'h10, 4'hF);
        len_r = len;
        // Pin high in strobe cycle hold+1, filtered four later, then release
        check("stretch", len, 14);
        ACC_WDATA <= 32'h1234_5678;
        acc(1'b1, 3'h2, 27'h10, 4'h0);
        check("write stretch", len, len_r);
        check("write data", {doe, dout}, 33'h1_1234_5678);
        hold <= 4'h0;
        acc(1'b0, 3'h2, 27'h10, 4'hF);
        check("wait high", len, 6);
        check("read data", ard, word);
        // Lane modes, read and write
        ACC_TACC <= 4'h2;
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `EWB_ADDR_BWC, k[1] ? 32'h800 : 32'h0);
            acc(k[0], 3'h2, 27'h20, 4'hA);
            check("lanes", lanes, k[0] ? 4'hA : (k[1] ? 4'h0 : 4'hF));
            check("chip select", csl, 1'b0);
        end
        // SDRAM bank select for every size and part kind
        apb(1'b1, `EWB_ADDR_BWC, 32'h0);
        for (k = 0; k < 28; k++) begin
            hi = 20 + k / 4;
            fb = k[1] | (k / 4 >= 5);
            pat = k[0] ? 32'h2AA_AAAA : 32'h555_5555;
            if (k / 4 < 2 && k[1]) continue;
            apb(1'b1, `EWB_ADDR_CFG, {28'h0, k[1], 3'(k / 4)});
            acc(1'b0, 3'h6, pat[26:0], 4'hF);
            check("bank select", bsel, fb ? {pat[hi], pat[hi - 1]} : {1'b0, pat[hi]});
        end
        // External master takes and returns the bus
        BUS_REQUEST_N <= 1'b0;
        for (k = 0; k < 10 && BUS_GRANT_N !== 1'b0; k++) @(negedge CORE_CLK);
        check("grant", BUS_GRANT_N, 1'b0);
        check("float", {MEM_ADDR_OE, MEM_DATA_OE, MEM_CTRL_OE, ACC_READY}, 4'h0);
        apb(1'b0, `EWB_ADDR_CFG, 32'h0);
        check("granted flag", rd[8], 1'b1);
        @(posedge CORE_CLK);
        BUS_REQUEST_N <= 1'b1;
        for (k = 0; k < 10 && BUS_GRANT_N !== 1'b1; k++) @(negedge CORE_CLK);
        check("release", {BUS_GRANT_N, MEM_ADDR_OE, MEM_CTRL_OE}, 3'h7);
        close_out();
    end
endmodule : test_ewb_mem_ctrl
